/* File: rtl/three_port_parallel_io.sv */
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module three_port_parallel_io (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite slave
  input  wire logic [port_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [port_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [port_pkg::STRB_W-1:0]    s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [port_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [port_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // first port pins
  input  wire logic [port_pkg::FIRST_W-1:0]   first_pin_in,
  output logic [port_pkg::FIRST_W-1:0]        first_pin_out,
  output logic [port_pkg::FIRST_W-1:0]        first_pin_oe_n,
  // second port pins, shared with the serial comm unit
  input  wire logic [port_pkg::SECOND_W-1:0]  second_pin_in,
  output logic [port_pkg::SECOND_W-1:0]       second_pin_out,
  output logic [port_pkg::SECOND_W-1:0]       second_pin_oe_n,
  // third port pins
  input  wire logic [port_pkg::THIRD_W-1:0]   third_pin_in,
  output logic [port_pkg::THIRD_W-1:0]        third_pin_out,
  output logic [port_pkg::THIRD_W-1:0]        third_pin_oe_n,
  // to the motor pwm unit
  output logic                                first_fault_input,
  output logic                                fourth_fault_input
);
  import port_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // write channel state
  logic                 aw_full_reg;
  logic                 w_full_reg;
  logic [ADDR_W-1:0]    awaddr_reg;
  logic [DATA_W-1:0]    wdata_reg;
  logic                 wlane0_reg;
  logic                 awready_reg;
  logic                 wready_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  // read channel state
  logic                 arready_reg;
  logic                 rvalid_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic [1:0]           rresp_reg;
  // fault outputs
  logic                 first_fault_reg;
  logic                 fourth_fault_reg;

  wire                  aw_hs;
  wire                  w_hs;
  wire                  ar_hs;
  wire                  do_write;
  wire                  aw_full_next;
  wire                  w_full_next;
  wire                  bvalid_next;
  wire                  rvalid_next;
  wire [REG_COUNT-1:0]  wr_sel;
  wire [REG_COUNT-1:0]  rd_sel;
  wire                  wr_hit;
  wire                  rd_hit;
  wire [DATA_W-1:0]     rd_word;
  wire                  first_fault_next;
  wire                  fourth_fault_next;

  wire [FIRST_W-1:0]    first_latch;
  wire [FIRST_W-1:0]    first_dir;
  wire [FIRST_W-1:0]    first_oe_n;
  wire [FIRST_W-1:0]    first_read;
  wire [SECOND_W-1:0]   second_latch;
  wire [SECOND_W-1:0]   second_dir;
  wire [SECOND_W-1:0]   second_oe_n;
  wire [SECOND_W-1:0]   second_read;
  wire [THIRD_W-1:0]    third_latch;
  wire [THIRD_W-1:0]    third_dir;
  wire [THIRD_W-1:0]    third_oe_n;
  wire [THIRD_W-1:0]    third_read;

  //////////////////////////////////////////////////////////////////////
  // handshakes and write sequencing
  assign aw_hs        = s_axi_awvalid & awready_reg;
  assign w_hs         = s_axi_wvalid & wready_reg;
  assign ar_hs        = s_axi_arvalid & arready_reg;
  // both halves held and no response pending
  assign do_write     = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign aw_full_next = (aw_full_reg | aw_hs) & ~do_write;
  assign w_full_next  = (w_full_reg | w_hs) & ~do_write;
  assign bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
  assign rvalid_next  = ar_hs | (rvalid_reg & ~s_axi_rready);

  // lanes 1..3 carry only unused bits, so only lane 0 matters
  assign wr_sel = reg_decode(awaddr_reg) & {REG_COUNT{do_write & wlane0_reg}};
  assign wr_hit = |reg_decode(awaddr_reg);
  assign rd_sel = reg_decode(s_axi_araddr);
  assign rd_hit = |rd_sel;

  // unused bits stay zero in the read word
  assign rd_word =
      ({DATA_W{rd_sel[SEL_FIRST_DATA]}}  & DATA_W'(first_read))
    | ({DATA_W{rd_sel[SEL_SECOND_DATA]}} & DATA_W'(second_read))
    | ({DATA_W{rd_sel[SEL_THIRD_DATA]}}  & DATA_W'(third_read))
    | ({DATA_W{rd_sel[SEL_FIRST_DIR]}}   & DATA_W'(first_dir))
    | ({DATA_W{rd_sel[SEL_SECOND_DIR]}}  & DATA_W'(second_dir))
    | ({DATA_W{rd_sel[SEL_THIRD_DIR]}}   & DATA_W'(third_dir));

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg  <= ~w_full_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
      if (do_write)
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end
  end

  // payload holders need no reset: only read while their flag is set
  always_ff @(posedge aclk)
  begin
    if (aw_hs)
      awaddr_reg <= s_axi_awaddr;
    if (w_hs)
    begin
      wdata_reg  <= s_axi_wdata;
      wlane0_reg <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end
    else
    begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_hs)
      begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  port_bank #(.WIDTH(FIRST_W), .DIR_RESET(FIRST_DIR_RESET)) first_bank (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .data_we    (wr_sel[SEL_FIRST_DATA]),
    .dir_we     (wr_sel[SEL_FIRST_DIR]),
    .wr_value   (wdata_reg[FIRST_W-1:0]),
    .pin_in     (first_pin_in),
    .latch_reg  (first_latch),
    .dir_reg    (first_dir),
    .oe_n_reg   (first_oe_n),
    .read_value (first_read)
  );

  port_bank #(.WIDTH(SECOND_W), .DIR_RESET(SECOND_DIR_RESET)) second_bank (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .data_we    (wr_sel[SEL_SECOND_DATA]),
    .dir_we     (wr_sel[SEL_SECOND_DIR]),
    .wr_value   (wdata_reg[SECOND_W-1:0]),
    .pin_in     (second_pin_in),
    .latch_reg  (second_latch),
    .dir_reg    (second_dir),
    .oe_n_reg   (second_oe_n),
    .read_value (second_read)
  );

  port_bank #(.WIDTH(THIRD_W), .DIR_RESET(THIRD_DIR_RESET)) third_bank (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .data_we    (wr_sel[SEL_THIRD_DATA]),
    .dir_we     (wr_sel[SEL_THIRD_DIR]),
    .wr_value   (wdata_reg[THIRD_W-1:0]),
    .pin_in     (third_pin_in),
    .latch_reg  (third_latch),
    .dir_reg    (third_dir),
    .oe_n_reg   (third_oe_n),
    .read_value (third_read)
  );

  //////////////////////////////////////////////////////////////////////
  // an output pin must not look like a fault to the pwm unit
  assign first_fault_next  = third_dir[0] ? FAULT_IDLE : third_pin_in[0];
  assign fourth_fault_next = third_dir[1] ? FAULT_IDLE : third_pin_in[1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_fault_reg  <= FAULT_IDLE;
      fourth_fault_reg <= FAULT_IDLE;
    end
    else
    begin
      first_fault_reg  <= first_fault_next;
      fourth_fault_reg <= fourth_fault_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign s_axi_awready      = awready_reg;
  assign s_axi_wready       = wready_reg;
  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_arready      = arready_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rdata        = rdata_reg;
  assign s_axi_rresp        = rresp_reg;
  assign first_pin_out      = first_latch;
  assign first_pin_oe_n     = first_oe_n;
  assign second_pin_out     = second_latch;
  assign second_pin_oe_n    = second_oe_n;
  assign third_pin_out      = third_latch;
  assign third_pin_oe_n     = third_oe_n;
  assign first_fault_input  = first_fault_reg;
  assign fourth_fault_input = fourth_fault_reg;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_dir_reset;
    @(posedge aclk) !aresetn |=> (first_dir == FIRST_DIR_RESET)
      && (second_dir == SECOND_DIR_RESET) && (third_dir == THIRD_DIR_RESET);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction bits not cleared by reset");

  // case equality: a latch stays unknown until its first write
  property p_latch_keeps;
    @(posedge aclk) !aresetn |=> (first_latch === $past(first_latch))
      && (second_latch === $past(second_latch)) && (third_latch === $past(third_latch));
  endproperty
  a_latch_keeps: assert property (p_latch_keeps)
    else $error("data latch changed by reset");

  property p_oe_follows_dir;
    @(posedge aclk) disable iff (!aresetn)
      (first_pin_oe_n == ~first_dir) && (second_pin_oe_n == ~second_dir)
      && (third_pin_oe_n == ~third_dir);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("pin enable disagrees with direction");

  property p_first_latch_write;
    @(posedge aclk) disable iff (!aresetn)
      do_write && wlane0_reg && (awaddr_reg[ADDR_W-1:2] == IDX_FIRST_DATA)
      |=> first_latch == $past(wdata_reg[FIRST_W-1:0]);
  endproperty
  a_first_latch_write: assert property (p_first_latch_write)
    else $error("first port latch missed a write");

  property p_read_first;
    @(posedge aclk) disable iff (!aresetn)
      ar_hs && (s_axi_araddr[ADDR_W-1:2] == IDX_FIRST_DATA)
      |=> s_axi_rvalid && (s_axi_rdata[FIRST_W-1:0] ==
          (($past(first_latch) & $past(first_dir))
          | ($past(first_pin_in) & ~$past(first_dir))));
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("first port read mixes latch and pin wrongly");

  property p_read_second;
    @(posedge aclk) disable iff (!aresetn)
      ar_hs && (s_axi_araddr[ADDR_W-1:2] == IDX_SECOND_DATA)
      |=> (s_axi_rdata[SECOND_W-1:0] == (($past(second_latch) & $past(second_dir))
          | ($past(second_pin_in) & ~$past(second_dir))));
  endproperty
  a_read_second: assert property (p_read_second)
    else $error("second port read mixes latch and pin wrongly");

  property p_read_third;
    @(posedge aclk) disable iff (!aresetn)
      ar_hs && (s_axi_araddr[ADDR_W-1:2] == IDX_THIRD_DATA)
      |=> (s_axi_rdata[THIRD_W-1:0] == (($past(third_latch) & $past(third_dir))
          | ($past(third_pin_in) & ~$past(third_dir))));
  endproperty
  a_read_third: assert property (p_read_third)
    else $error("third port read mixes latch and pin wrongly");

  property p_unused_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[DATA_W-1:FIRST_W] == '0);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused read bits not zero");

  property p_fault_masked;
    @(posedge aclk) disable iff (!aresetn)
      third_dir[0] |=> (first_fault_input == FAULT_IDLE);
  endproperty
  a_fault_masked: assert property (p_fault_masked)
    else $error("output pin still feeds first fault input");

  property p_fault_passes;
    @(posedge aclk) disable iff (!aresetn)
      // release edge: the fault flop still takes its reset level there
      aresetn && !third_dir[1] |=> (fourth_fault_input == $past(third_pin_in[1]));
  endproperty
  a_fault_passes: assert property (p_fault_passes)
    else $error("input pin level not passed to fourth fault input");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
      aw_hs && w_hs && !bvalid_reg |=> do_write ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response not two cycles after handshake");

  c_write: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready && (s_axi_rresp == RESP_OKAY));
  c_fault_mask: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(third_dir[0]) ##1 third_pin_in[0]);
  c_decerr: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && (s_axi_bresp == RESP_DECERR));
endmodule : three_port_parallel_io

/* File: rtl/port_pkg.sv */
package port_pkg;
  localparam int FIRST_W  = 7;
  localparam int SECOND_W = 7;
  localparam int THIRD_W  = 2;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = 4;

  // register index; byte address is four times the index
  localparam logic [5:0] IDX_FIRST_DATA  = 6'h00;
  localparam logic [5:0] IDX_SECOND_DATA = 6'h01;
  localparam logic [5:0] IDX_THIRD_DATA  = 6'h02;
  localparam logic [5:0] IDX_FIRST_DIR   = 6'h04;
  localparam logic [5:0] IDX_SECOND_DIR  = 6'h05;
  localparam logic [5:0] IDX_THIRD_DIR   = 6'h06;

  // one-hot select positions
  localparam int REG_COUNT       = 6;
  localparam int SEL_FIRST_DATA  = 0;
  localparam int SEL_SECOND_DATA = 1;
  localparam int SEL_THIRD_DATA  = 2;
  localparam int SEL_FIRST_DIR   = 3;
  localparam int SEL_SECOND_DIR  = 4;
  localparam int SEL_THIRD_DIR   = 5;

  localparam logic [FIRST_W-1:0]  FIRST_DIR_RESET  = 7'h00;
  localparam logic [SECOND_W-1:0] SECOND_DIR_RESET = 7'h00;
  localparam logic [THIRD_W-1:0]  THIRD_DIR_RESET  = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // level handed to the pwm unit when a fault pin is not watched
  localparam logic FAULT_IDLE = 1'b0;

  function automatic logic [REG_COUNT-1:0] reg_decode(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    logic [REG_COUNT-1:0] sel;
    idx = addr[ADDR_W-1:2];
    sel = '0;
    sel[SEL_FIRST_DATA]  = (idx == IDX_FIRST_DATA);
    sel[SEL_SECOND_DATA] = (idx == IDX_SECOND_DATA);
    sel[SEL_THIRD_DATA]  = (idx == IDX_THIRD_DATA);
    sel[SEL_FIRST_DIR]   = (idx == IDX_FIRST_DIR);
    sel[SEL_SECOND_DIR]  = (idx == IDX_SECOND_DIR);
    sel[SEL_THIRD_DIR]   = (idx == IDX_THIRD_DIR);
    return sel;
  endfunction : reg_decode
endpackage : port_pkg

/* File: rtl/port_bank.sv */
`timescale 1ns/100ps
module port_bank #(
  parameter int               WIDTH     = 7,
  parameter logic [WIDTH-1:0] DIR_RESET = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             data_we,
  input  wire logic             dir_we,
  input  wire logic [WIDTH-1:0] wr_value,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] latch_reg,
  output logic      [WIDTH-1:0] dir_reg,
  output logic      [WIDTH-1:0] oe_n_reg,
  output logic      [WIDTH-1:0] read_value
);
  //////////////////////////////////////////////////////////////////////
  // latch has no reset on purpose: its content survives reset
  always_ff @(posedge aclk)
  begin
    if (data_we)
      latch_reg <= wr_value;
  end

  // enable kept in its own flop so the pin driver comes straight off a register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_reg  <= DIR_RESET;
      oe_n_reg <= ~DIR_RESET;
    end
    else if (dir_we)
    begin
      dir_reg  <= wr_value;
      oe_n_reg <= ~wr_value;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign read_value = (latch_reg & dir_reg) | (pin_in & ~dir_reg);
endmodule : port_bank

/* File: verification/pin_model.sv */
`timescale 1ns/100ps
module pin_model #(
  parameter int WIDTH = 7
) (
  input  wire logic [WIDTH-1:0] ext_level,
  input  wire logic [WIDTH-1:0] pin_out,
  input  wire logic [WIDTH-1:0] pin_oe_n,
  output logic      [WIDTH-1:0] pin_in
);
  // a driven pin shows the port's own level, a released one the board's
  always_comb
  begin
    for (int b = 0; b < WIDTH; b++)
    begin
      pin_in[b] = pin_oe_n[b] ? ext_level[b] : pin_out[b];
    end
  end
endmodule : pin_model

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import port_pkg::*;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [6:0]  first_in, first_out, first_oe_n, first_ext;
  logic [6:0]  second_in, second_out, second_oe_n, second_ext;
  logic [1:0]  third_in, third_out, third_oe_n, third_ext;
  logic        first_fault_input, fourth_fault_input;
  int          err_total, comparisons;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [31:0] msk, lat, ext, dm;

  three_port_parallel_io dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .first_pin_in(first_in), .first_pin_out(first_out), .first_pin_oe_n(first_oe_n),
    .second_pin_in(second_in), .second_pin_out(second_out), .second_pin_oe_n(second_oe_n),
    .third_pin_in(third_in), .third_pin_out(third_out), .third_pin_oe_n(third_oe_n),
    .first_fault_input(first_fault_input), .fourth_fault_input(fourth_fault_input));

  pin_model #(.WIDTH(7)) board_first (.ext_level(first_ext), .pin_out(first_out),
    .pin_oe_n(first_oe_n), .pin_in(first_in));
  pin_model #(.WIDTH(7)) board_second (.ext_level(second_ext), .pin_out(second_out),
    .pin_oe_n(second_oe_n), .pin_in(second_in));
  pin_model #(.WIDTH(2)) board_third (.ext_level(third_ext), .pin_out(third_out),
    .pin_oe_n(third_oe_n), .pin_in(third_in));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic give_verdict;
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t resp %h expected %h", $time, got, exp);
    end
  endtask : check_resp

  ////////////////////////////////////////////////////////////////////////////////
  // bready held from the start: a slow slave is still answered at once
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                           output logic [1:0] resp);
    int   n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_done)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_done)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
      @(posedge aclk);
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic ar_done;
    ar_done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (ar_done && s_axi_rvalid === 1'b1)
        break;
      if (s_axi_arready === 1'b1 && !ar_done)
      begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    axi_write(addr, data, rsp);
    check_resp(rsp, RESP_OKAY);
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    axi_read(addr, rd, rsp);
    check_resp(rsp, RESP_OKAY);
    check_word(rd, exp);
  endtask : rd_chk

  task automatic set_ext(input int i, input logic [6:0] v);
    @(posedge aclk);
    case (i)
      0: first_ext <= v;
      1: second_ext <= v;
      default: third_ext <= v[1:0];
    endcase
    repeat (2) @(posedge aclk);
    #1;
  endtask : set_ext

  function automatic logic [31:0] pins_of(input int i);
    case (i)
      0: return {18'h0, first_oe_n, first_out};
      1: return {18'h0, second_oe_n, second_out};
      default: return {23'h0, third_oe_n, 5'h0, third_out};
    endcase
  endfunction : pins_of

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    first_ext = 7'h33;
    second_ext = 7'h33;
    third_ext = 2'h3;
    do_reset();
    for (int i = 0; i < 3; i++)
    begin
      msk = (i == 2) ? 32'h03 : 32'h7f;
      lat = 32'h55 & msk;
      ext = 32'h33 & msk;
      dm = 32'h72 & msk;
      rd_chk(8'h10 + 8'(4 * i), 32'h0);
      check_word(pins_of(i) >> 7, msk);
      wr(8'(4 * i), 32'hffffff55);
      rd_chk(8'(4 * i), ext);
      wr(8'h10 + 8'(4 * i), 32'hffffffff);
      rd_chk(8'h10 + 8'(4 * i), msk);
      rd_chk(8'(4 * i), lat);
      check_word(pins_of(i), (i == 2) ? 32'h01 : lat);
      // bits 6, 5, 4 and 1 driven as on small packages (only bit 1 on the third port)
      wr(8'h10 + 8'(4 * i), dm);
      rd_chk(8'(4 * i), (lat & dm) | (ext & ~dm & msk));
      set_ext(i, 7'h4c);
      rd_chk(8'(4 * i), (lat & dm) | (32'h4c & ~dm & msk));
      wr(8'h10 + 8'(4 * i), 32'h0);
    end
    // fault mirroring: {fourth, first}
    set_ext(2, 7'h03);
    check_word({30'h0, fourth_fault_input, first_fault_input}, 32'h3);
    set_ext(2, 7'h02);
    check_word({30'h0, fourth_fault_input, first_fault_input}, 32'h2);
    set_ext(2, 7'h03);
    wr(8'h18, 32'h1);
    set_ext(2, 7'h03);
    check_word({30'h0, fourth_fault_input, first_fault_input}, 32'h2);
    wr(8'h18, 32'h3);
    set_ext(2, 7'h03);
    check_word({30'h0, fourth_fault_input, first_fault_input}, 32'h0);
    wr(8'h18, 32'h0);
    set_ext(2, 7'h03);
    check_word({30'h0, fourth_fault_input, first_fault_input}, 32'h3);
    // unmapped places answer with an error and read zero
    axi_write(8'h0c, 32'h1, rsp);
    check_resp(rsp, RESP_DECERR);
    axi_read(8'h1c, rd, rsp);
    check_resp(rsp, RESP_DECERR);
    check_word(rd, 32'h0);
    // mid-run reset: directions clear, latches survive
    wr(8'h14, 32'h7f);
    do_reset();
    rd_chk(8'h14, 32'h0);
    check_word(pins_of(1) >> 7, 32'h7f);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h10 + 8'(4 * i), 32'h7f);
      rd_chk(8'(4 * i), (i == 2) ? 32'h01 : 32'h55);
    end
    give_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    err_total++;
    give_verdict();
  end
endmodule : testbench
